//--- inc/gel_pkg.sv
package gel_pkg;

  // Register byte addresses on the Wishbone slave, one word each
  localparam logic [7:0] OFS_PIN_VALUE = 8'h00;
  localparam logic [7:0] OFS_PIN_DIRECTION = 8'h04;
  localparam logic [7:0] OFS_EDGE_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_EDGE_SENSE_LO = 8'h0c;
  localparam logic [7:0] OFS_EDGE_SENSE_HI = 8'h10;
  localparam logic [7:0] OFS_IRQ_SOURCE = 8'h14;
  localparam logic [7:0] OFS_EDGE_EVENT = 8'h18;
  localparam logic [7:0] OFS_CELL_MODE_LO = 8'h1c;
  localparam logic [7:0] OFS_CELL_MODE_HI = 8'h20;
  localparam logic [7:0] OFS_CELL_TRUTH_LO = 8'h24;
  localparam logic [7:0] OFS_CELL_TRUTH_HI = 8'h28;
  localparam logic [7:0] OFS_CELL_TRUTHX_LO = 8'h2c;
  localparam logic [7:0] OFS_CELL_TRUTHX_HI = 8'h30;
  localparam logic [7:0] OFS_EXTRA_CFG = 8'h34;

  // Reset values
  localparam logic [15:0] RST_PIN_VALUE = 16'hffff;
  localparam logic [15:0] RST_PIN_DIRECTION = 16'hffff;
  localparam logic [15:0] RST_EDGE_IRQ_MASK = 16'hffff;
  localparam logic [15:0] RST_EDGE_SENSE = 16'h0000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [7:0] RST_CELL_MODE = 8'h00;
  localparam logic [31:0] RST_CELL_TRUTH = 32'h0000_0000;
  localparam logic [7:0] RST_CELL_TRUTHX = 8'h00;

  // Field positions and widths
  localparam int MODE_LO_POS = 0;
  localparam int MODE_HI_POS = 4;
  localparam int EXTRA_AUTOCLR_BIT = 0;
  localparam int TRUTH_W = 8;

  // Edge sense codes
  localparam logic [1:0] SENSE_OFF = 2'b00;
  localparam logic [1:0] SENSE_RISE = 2'b01;
  localparam logic [1:0] SENSE_FALL = 2'b10;
  localparam logic [1:0] SENSE_BOTH = 2'b11;

  // Logic cell mode codes
  localparam logic [1:0] MODE_GPIO = 2'b00;
  localparam logic [1:0] MODE_2IN = 2'b01;
  localparam logic [1:0] MODE_3IN = 2'b10;
  localparam logic [1:0] MODE_3TO2 = 2'b11;

  typedef enum logic [1:0] {
    GEL_BUS_IDLE = 2'b01,
    GEL_BUS_ACK = 2'b10
  } gel_bus_st_t;

endpackage

//--- rtl/gel_cell_bank.sv
`timescale 1ns/100ps
`default_nettype none

module gel_cell_bank
  import gel_pkg::*;
(
  input wire logic [7:0] mode_i,
  input wire logic [31:0] truth_i,
  input wire logic [7:0] truthx_i,
  input wire logic allow_3to2_i,
  input wire logic [7:0] lvl_i,
  output logic [7:0] cell_val_o,
  output logic [7:0] drive_o,
  output logic [7:0] input_o
);

  function automatic logic lut(input logic [7:0] tab, input logic [2:0] idx);
    lut = tab[idx];
  endfunction

  logic [1:0] lo;
  logic [1:0] hi;
  logic [7:0] t0, t1, t2, t3;

  always_comb begin
    lo = mode_i[MODE_LO_POS +: 2];
    hi = mode_i[MODE_HI_POS +: 2];
    t0 = truth_i[0*TRUTH_W +: TRUTH_W];
    t1 = truth_i[1*TRUTH_W +: TRUTH_W];
    t2 = truth_i[2*TRUTH_W +: TRUTH_W];
    t3 = truth_i[3*TRUTH_W +: TRUTH_W];
    cell_val_o = 8'h00;
    drive_o = 8'h00;
    input_o = 8'h00;
    if (lo == MODE_3TO2 && !allow_3to2_i) begin
      lo = MODE_GPIO;
    end
    case (lo)
      MODE_2IN: begin
        input_o[1:0] = 2'b11;
        drive_o[2] = 1'b1;
        cell_val_o[2] = lut(t0, {1'b0, lvl_i[1:0]});
      end
      MODE_3IN: begin
        input_o[2:0] = 3'b111;
        drive_o[3] = 1'b1;
        cell_val_o[3] = lut(t1, lvl_i[2:0]);
      end
      MODE_3TO2: begin
        input_o[2:0] = 3'b111;
        drive_o[4:3] = 2'b11;
        cell_val_o[3] = lut(t1, lvl_i[2:0]);
        cell_val_o[4] = lut(truthx_i, lvl_i[2:0]);
      end
      default: begin
      end
    endcase
    // Upper field is overridden while the lower one runs two outputs
    if (lo != MODE_3TO2) begin
      case (hi)
        MODE_2IN: begin
          input_o[5:4] = 2'b11;
          drive_o[6] = 1'b1;
          cell_val_o[6] = lut(t2, {1'b0, lvl_i[5:4]});
        end
        MODE_3IN: begin
          input_o[6:4] = 3'b111;
          drive_o[7] = 1'b1;
          cell_val_o[7] = lut(t3, lvl_i[6:4]);
        end
        default: begin
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- rtl/gel_edge_irq.sv
`timescale 1ns/100ps
`default_nettype none

module gel_edge_irq
  import gel_pkg::*;
#(
  parameter int NUM_CH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_CH-1:0] pin_in_i,
  output logic [NUM_CH-1:0] pin_out_o,
  output logic [NUM_CH-1:0] pin_oe_o,
  output logic irq_out_n_o,
  output logic irq_out_n_oe_o
);

  localparam int NB = (NUM_CH > 8) ? 2 : 1;
  localparam logic [15:0] CH_MASK = 16'((32'h1 << NUM_CH) - 1);
  localparam logic HAS_AUTOCLR = (NUM_CH == 16);
  localparam logic HAS_3TO2 = (NUM_CH > 4);

  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] prev;
    logic [2:0] arm;
    logic [15:0] dout;
    logic [15:0] dir;
    logic [15:0] mask;
    logic [15:0] sense_lo;
    logic [15:0] sense_hi;
    logic [15:0] src;
    logic [15:0] evt;
    logic [7:0] mode_lo;
    logic [7:0] mode_hi;
    logic [31:0] truth_lo;
    logic [31:0] truth_hi;
    logic [7:0] truthx_lo;
    logic [7:0] truthx_hi;
    logic autoclr;
    gel_bus_st_t bus;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] pout;
    logic [15:0] poe;
    logic irq_lvl;
    logic irq_oe;
  } gel_state_t;

  gel_state_t st;
  gel_state_t next_st;

  logic [15:0] cell_val;
  logic [15:0] cell_drive;
  logic [15:0] cell_input;

  function automatic gel_state_t reset_state();
    gel_state_t r;
    r = '0;
    r.prev = 16'h0000;
    r.arm = 3'h0;
    r.dout = RST_PIN_VALUE;
    r.dir = RST_PIN_DIRECTION;
    r.mask = RST_EDGE_IRQ_MASK;
    r.sense_lo = RST_EDGE_SENSE;
    r.sense_hi = RST_EDGE_SENSE;
    r.src = RST_FLAGS;
    r.evt = RST_FLAGS;
    r.mode_lo = RST_CELL_MODE;
    r.mode_hi = RST_CELL_MODE;
    r.truth_lo = RST_CELL_TRUTH;
    r.truth_hi = RST_CELL_TRUTH;
    r.truthx_lo = RST_CELL_TRUTHX;
    r.truthx_hi = RST_CELL_TRUTHX;
    r.bus = GEL_BUS_IDLE;
    r.poe = 16'h0000;
    r.pout = RST_PIN_VALUE;
    r.irq_lvl = 1'b1;
    r.irq_oe = 1'b0;
    return r;
  endfunction

  function automatic logic sense_hit(input logic [1:0] code,
                                     input logic rise, input logic fall);
    case (code)
      SENSE_RISE: sense_hit = rise;
      SENSE_FALL: sense_hit = fall;
      SENSE_BOTH: sense_hit = rise | fall;
      default: sense_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // One logic-cell group per eight-pin bank
  generate
    for (genvar b = 0; b < 2; b++) begin : g_bank
      if (b < NB) begin : g_on
        gel_cell_bank u_bank (
          .mode_i((b == 0) ? st.mode_lo : st.mode_hi),
          .truth_i((b == 0) ? st.truth_lo : st.truth_hi),
          .truthx_i((b == 0) ? st.truthx_lo : st.truthx_hi),
          .allow_3to2_i(HAS_3TO2),
          .lvl_i(st.sync2[b*8 +: 8]),
          .cell_val_o(cell_val[b*8 +: 8]),
          .drive_o(cell_drive[b*8 +: 8]),
          .input_o(cell_input[b*8 +: 8])
        );
      end else begin : g_off
        assign cell_val[b*8 +: 8] = 8'h00;
        assign cell_drive[b*8 +: 8] = 8'h00;
        assign cell_input[b*8 +: 8] = 8'h00;
      end
    end
  endgenerate

  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] qual;
  logic [15:0] clr_src;
  logic [15:0] clr_evt;
  logic [31:0] wmerged;
  logic [31:0] rd;
  logic req;
  logic [31:0] sense_all;

  always_comb begin
    next_st = st;
    rise = 16'h0000;
    fall = 16'h0000;
    qual = 16'h0000;
    clr_src = 16'h0000;
    clr_evt = 16'h0000;
    wmerged = 32'h0000_0000;
    rd = 32'h0000_0000;
    req = 1'b0;

    // Pins come from outside the clock domain
    next_st.sync1 = 16'(pin_in_i);
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    // Edges are ignored until the synchronisers hold real pin levels
    next_st.arm = {st.arm[1:0], 1'b1};

    // Cell pins are sensed exactly like GPIO pins
    rise = st.sync2 & ~st.prev;
    fall = ~st.sync2 & st.prev;
    // Both sense words side by side, so pin i always sits at bits 2i+1:2i
    sense_all = {st.sense_hi, st.sense_lo};
    for (int i = 0; i < 16; i++) begin
      qual[i] = st.arm[2] & CH_MASK[i] & sense_hit(
        sense_all[2*i +: 2], rise[i], fall[i]);
    end

    // Wishbone classic slave, one wait state
    next_st.ack = 1'b0;
    case (st.bus)
      GEL_BUS_IDLE: begin
        req = wb_cyc_i & wb_stb_i;
        if (req) begin
          next_st.bus = GEL_BUS_ACK;
          next_st.ack = 1'b1;
        end
      end
      GEL_BUS_ACK: begin
        next_st.bus = GEL_BUS_IDLE;
      end
      default: begin
        next_st.bus = GEL_BUS_IDLE;
      end
    endcase

    case (wb_adr_i)
      OFS_PIN_VALUE: begin
        rd = {16'h0000, st.sync2};
      end
      OFS_PIN_DIRECTION: begin
        rd = {16'h0000, st.dir & CH_MASK};
      end
      OFS_EDGE_IRQ_MASK: begin
        rd = {16'h0000, st.mask & CH_MASK};
      end
      OFS_EDGE_SENSE_LO: begin
        rd = {16'h0000, st.sense_lo};
      end
      OFS_EDGE_SENSE_HI: begin
        rd = {16'h0000, st.sense_hi};
      end
      OFS_IRQ_SOURCE: begin
        rd = {16'h0000, st.src};
      end
      OFS_EDGE_EVENT: begin
        rd = {16'h0000, st.evt};
      end
      OFS_CELL_MODE_LO: begin
        rd = {24'h000000, st.mode_lo};
      end
      OFS_CELL_MODE_HI: begin
        rd = {24'h000000, st.mode_hi};
      end
      OFS_CELL_TRUTH_LO: begin
        rd = st.truth_lo;
      end
      OFS_CELL_TRUTH_HI: begin
        rd = st.truth_hi;
      end
      OFS_CELL_TRUTHX_LO: begin
        rd = {24'h000000, st.truthx_lo};
      end
      OFS_CELL_TRUTHX_HI: begin
        rd = {24'h000000, st.truthx_hi};
      end
      OFS_EXTRA_CFG: begin
        rd = {31'h0000_0000, st.autoclr};
      end
      default: begin
        rd = 32'h0000_0000;
      end
    endcase
    wmerged = lane_merge(rd, wb_dat_i, wb_sel_i);
    if (req) begin
      next_st.rdata = rd;
    end

    if (req && wb_we_i) begin
      case (wb_adr_i)
        OFS_PIN_VALUE: next_st.dout = wmerged[15:0] & CH_MASK;
        OFS_PIN_DIRECTION: next_st.dir = wmerged[15:0] & CH_MASK;
        OFS_EDGE_IRQ_MASK: next_st.mask = wmerged[15:0] & CH_MASK;
        OFS_EDGE_SENSE_LO: next_st.sense_lo = wmerged[15:0];
        OFS_EDGE_SENSE_HI: begin
          if (NUM_CH > 8) begin
            next_st.sense_hi = wmerged[15:0];
          end
        end
        OFS_IRQ_SOURCE: begin
          // Only the full all-ones pattern clears, partial writes do not
          if ((wmerged[15:0] & CH_MASK) == CH_MASK) begin
            clr_src = 16'hffff;
            clr_evt = st.src;
          end
        end
        OFS_EDGE_EVENT: clr_evt = wmerged[15:0];
        OFS_CELL_MODE_LO: next_st.mode_lo = wmerged[7:0];
        OFS_CELL_MODE_HI: begin
          if (NUM_CH > 8) begin
            next_st.mode_hi = wmerged[7:0];
          end
        end
        OFS_CELL_TRUTH_LO: next_st.truth_lo = wmerged;
        OFS_CELL_TRUTH_HI: begin
          if (NUM_CH > 8) begin
            next_st.truth_hi = wmerged;
          end
        end
        OFS_CELL_TRUTHX_LO: next_st.truthx_lo = wmerged[7:0];
        OFS_CELL_TRUTHX_HI: begin
          if (NUM_CH > 8) begin
            next_st.truthx_hi = wmerged[7:0];
          end
        end
        OFS_EXTRA_CFG: begin
          if (HAS_AUTOCLR) begin
            next_st.autoclr = wmerged[EXTRA_AUTOCLR_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    if (req && !wb_we_i && wb_adr_i == OFS_PIN_VALUE && st.autoclr) begin
      clr_src = 16'hffff;
      clr_evt = clr_evt | st.src;
    end

    // A new edge in the clearing cycle survives the clear
    next_st.src = (st.src & ~clr_src) | (qual & ~st.mask);
    next_st.evt = (st.evt & ~clr_evt) | qual;
    next_st.irq_lvl = ~(|next_st.src);
    next_st.irq_oe = |next_st.src;

    // Cell roles override the direction register
    next_st.pout = CH_MASK & ((cell_drive & cell_val) |
                              (~cell_drive & st.dout));
    next_st.poe = CH_MASK & (cell_drive |
                  (~cell_input & ~st.dir));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= reset_state();
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign pin_out_o = st.pout[NUM_CH-1:0];
  assign pin_oe_o = st.poe[NUM_CH-1:0];
  assign irq_out_n_o = st.irq_lvl;
  assign irq_out_n_oe_o = st.irq_oe;

endmodule

`default_nettype wire

//--- tb/gel_edge_irq_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module gel_edge_irq_monitor
  import gel_pkg::*;
#(
  parameter int NUM_CH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NUM_CH-1:0] pin_in_i,
  input wire logic [NUM_CH-1:0] pin_oe_o,
  input wire logic irq_out_n_o,
  input wire logic irq_out_n_oe_o
);
  logic [3:0] quiet;
  logic [NUM_CH-1:0] pin_q;
  logic mask_wr;
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Saturating count of cycles the pads held still
  always_ff @(posedge clk_i) begin
    pin_q <= pin_in_i;
    if (rst_i || pin_in_i != pin_q) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
    if (rst_i) mask_wr <= 1'b0;
    else if (req && wb_we_i && wb_adr_i == OFS_EDGE_IRQ_MASK) mask_wr <= 1'b1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_timing: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without request");
  a_irq_oe_pair: assert property (irq_out_n_oe_o == !irq_out_n_o)
    else $error("interrupt enable disagrees with level");
  a_reset_release: assert property (disable iff (1'b0)
    rst_i |=> irq_out_n_o && !irq_out_n_oe_o && pin_oe_o == '0)
    else $error("reset left a pin driven");
  a_mask_blocks: assert property (!mask_wr |-> irq_out_n_o)
    else $error("interrupt while all pins masked");
  a_clear_irq: assert property (req && wb_we_i &&
    wb_adr_i == OFS_IRQ_SOURCE && wb_sel_i == 4'hf &&
    (&wb_dat_i[NUM_CH-1:0]) |=> irq_out_n_o)
    else $error("interrupt not released by clear");
  a_irq_cause: assert property ($fell(irq_out_n_o) |-> quiet < 4'h6)
    else $error("interrupt without a pin edge");
  a_irq_holds: assert property ($rose(irq_out_n_o) |-> wb_ack_o)
    else $error("interrupt released without host access");
  a_pin_readback: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == OFS_PIN_VALUE && quiet > 4'h4 |->
    wb_dat_o[NUM_CH-1:0] == pin_in_i)
    else $error("pin value read differs from pads");
  c_irq: cover property ($fell(irq_out_n_o));
  c_clear: cover property (req && wb_we_i && wb_adr_i == OFS_IRQ_SOURCE);
  c_cell: cover property ((|pin_oe_o) && quiet > 4'h4);
endmodule

bind gel_edge_irq gel_edge_irq_monitor #(.NUM_CH(NUM_CH)) u_gel_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pin_in_i(pin_in_i), .pin_oe_o(pin_oe_o), .irq_out_n_o(irq_out_n_o),
  .irq_out_n_oe_o(irq_out_n_oe_o)
);

`default_nettype wire

//--- tb/gel_pin_env.sv
`timescale 1ns/100ps
`default_nettype none

module gel_pin_env #(
  parameter int NUM_CH = 16
) (
  input wire logic [NUM_CH-1:0] ext_i,
  input wire logic [NUM_CH-1:0] pin_out_i,
  input wire logic [NUM_CH-1:0] pin_oe_i,
  input wire logic irq_n_i,
  input wire logic irq_oe_i,
  output logic [NUM_CH-1:0] pad_o,
  output logic irq_wire_o
);
  // Driven pins read back the device, the rest follow the board
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      pad_o[i] = pin_oe_i[i] ? pin_out_i[i] : ext_i[i];
    end
  end
  // Open drain with pull-up: released reads high, not the last level
  assign irq_wire_o = irq_oe_i ? irq_n_i : 1'b1;
endmodule

`default_nettype wire

//--- tb/test_gpio_edge_irq_and_logic_cells.sv
`timescale 1ns/100ps
`default_nettype none

module test_gpio_edge_irq_and_logic_cells
  import gel_pkg::*;
;
  localparam int N = 16;
  localparam logic [31:0] TT = 32'hfe068008;
  localparam logic [7:0] T4 = 8'h01;
  localparam logic [7:0] MODES [7] = '{8'h00, 8'h01, 8'h12, 8'h21, 8'h10,
    8'h13, 8'h33};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [N-1:0] ext = '0;
  logic [31:0] rdat;
  logic ack, irq_n, irq_oe, irq_wire;
  logic [N-1:0] pout, poe, pad;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int fails = 0;
  int tests_run = 0;
  int seed = 29;
  logic [7:0] md;
  logic [15:0] v;

  always #2.5 clk_i = ~clk_i;

  gel_edge_irq #(.NUM_CH(N)) u_gel_edge_irq (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pin_in_i(pad), .pin_out_o(pout),
    .pin_oe_o(poe), .irq_out_n_o(irq_n), .irq_out_n_oe_o(irq_oe)
  );
  gel_pin_env #(.NUM_CH(N)) u_gel_pin_env (
    .ext_i(ext), .pin_out_i(pout), .pin_oe_i(poe), .irq_n_i(irq_n),
    .irq_oe_i(irq_oe), .pad_o(pad), .irq_wire_o(irq_wire)
  );

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // Level is looked at mid-cycle so the edge's updates have landed
  task automatic cmp_irq(input logic want);
    @(negedge clk_i);
    cmp({31'h0, irq_wire}, {31'h0, want});
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= a;
    we <= w;
    dat <= d;
    sel <= 4'hf;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) begin
      fails++;
      end_of_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] k);
    exp_q.push_back(x & k);
    msk_q.push_back(k);
    wb(a, 1'b0, 32'h0);
  endtask

  task automatic pins(input logic [N-1:0] p);
    @(posedge clk_i);
    ext <= p;
    repeat (8) @(posedge clk_i);
  endtask

  function automatic logic [7:0] bank(input logic [7:0] m,
                                      input logic [7:0] p);
    logic [7:0] r;
    r = 8'h00;
    if (m[1:0] == MODE_3TO2) begin
      r[2:0] = p[2:0];
      r[3] = TT[8 + p[2:0]];
      r[4] = T4[p[2:0]];
    end else begin
      if (m[1:0] == MODE_2IN) r[2:0] = {TT[p[1:0]], p[1:0]};
      if (m[1:0] == MODE_3IN) r[3:0] = {TT[8 + p[2:0]], p[2:0]};
      if (m[5:4] == MODE_2IN) r[6:4] = {TT[16 + p[5:4]], p[5:4]};
      if (m[5:4] == MODE_3IN) r[7:4] = {TT[24 + p[6:4]], p[6:4]};
    end
    return r;
  endfunction

  // Results are paired with notes in issue order; reads never overlap
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      cmp(rdat & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_PIN_DIRECTION, 32'hffff, 32'hffff);
    rd(OFS_EDGE_IRQ_MASK, 32'hffff, 32'hffff);
    rd(OFS_IRQ_SOURCE, 32'h0, 32'hffff);
    rd(OFS_EDGE_EVENT, 32'h0, 32'hffff);
    rd(8'h3c, 32'h0, 32'hffffffff);
    cmp_irq(1'b1);
    wb(OFS_EDGE_IRQ_MASK, 1'b1, 32'hfffd);
    for (int c = 0; c < 4; c++) begin
      wb(OFS_EDGE_SENSE_LO, 1'b1, 32'(c) << 2);
      pins(16'h0002);
      rd(OFS_IRQ_SOURCE, {30'h0, c[0], 1'b0}, 32'hffff);
      cmp_irq(~c[0]);
      wb(OFS_IRQ_SOURCE, 1'b1, 32'h00ff);
      cmp_irq(~c[0]);
      wb(OFS_IRQ_SOURCE, 1'b1, 32'hffff);
      cmp_irq(1'b1);
      pins(16'h0000);
      rd(OFS_IRQ_SOURCE, {30'h0, c[1], 1'b0}, 32'hffff);
      cmp_irq(~c[1]);
      wb(OFS_IRQ_SOURCE, 1'b1, 32'hffff);
      rd(OFS_EDGE_EVENT, 32'h0, 32'h0002);
    end
    wb(OFS_EDGE_IRQ_MASK, 1'b1, 32'hffff);
    pins(16'h0002);
    rd(OFS_IRQ_SOURCE, 32'h0, 32'hffff);
    rd(OFS_EDGE_EVENT, 32'h2, 32'hffff);
    cmp_irq(1'b1);
    wb(OFS_EXTRA_CFG, 1'b1, 32'h1);
    wb(OFS_EDGE_IRQ_MASK, 1'b1, 32'hfffd);
    pins(16'h0000);
    cmp_irq(1'b0);
    rd(OFS_PIN_VALUE, 32'h0, 32'hffff);
    cmp_irq(1'b1);
    rd(OFS_IRQ_SOURCE, 32'h0, 32'hffff);
    wb(OFS_EXTRA_CFG, 1'b1, 32'h0);
    wb(OFS_EDGE_EVENT, 1'b1, 32'hffff);
    // Every pin set to drive 0, so a cell pin not forced shows up
    wb(OFS_EDGE_IRQ_MASK, 1'b1, 32'hffff);
    wb(OFS_PIN_VALUE, 1'b1, 32'h0);
    wb(OFS_PIN_DIRECTION, 1'b1, 32'h0);
    wb(OFS_CELL_TRUTH_LO, 1'b1, TT);
    wb(OFS_CELL_TRUTH_HI, 1'b1, TT);
    wb(OFS_CELL_TRUTHX_LO, 1'b1, {24'h0, T4});
    wb(OFS_CELL_TRUTHX_HI, 1'b1, {24'h0, T4});
    for (int k = 0; k < 7; k++) begin
      md = MODES[k];
      wb(OFS_CELL_MODE_LO, 1'b1, {24'h0, md});
      wb(OFS_CELL_MODE_HI, 1'b1, {24'h0, md});
      for (int j = 0; j < 4; j++) begin
        v = 16'($random(seed));
        pins(v);
        rd(OFS_PIN_VALUE, {16'h0, bank(md, v[15:8]), bank(md, v[7:0])},
           32'hffff);
      end
    end
    wb(OFS_CELL_MODE_LO, 1'b1, 32'h1);
    wb(OFS_CELL_MODE_HI, 1'b1, 32'h0);
    wb(OFS_EDGE_SENSE_LO, 1'b1, 32'h10);
    pins(16'h0000);
    wb(OFS_IRQ_SOURCE, 1'b1, 32'hffff);
    wb(OFS_EDGE_IRQ_MASK, 1'b1, 32'hfffb);
    pins(16'h0003);
    rd(OFS_IRQ_SOURCE, 32'h4, 32'hffff);
    cmp_irq(1'b0);
    // Upper bank sensing, edge made by a plain output pin
    wb(OFS_EDGE_SENSE_HI, 1'b1, 32'h4);
    wb(OFS_EDGE_IRQ_MASK, 1'b1, 32'hfdff);
    wb(OFS_IRQ_SOURCE, 1'b1, 32'hffff);
    wb(OFS_PIN_VALUE, 1'b1, 32'h0200);
    pins(16'h0003);
    rd(OFS_IRQ_SOURCE, 32'h200, 32'hffff);
    cmp_irq(1'b0);
    end_of_test();
  end
endmodule

`default_nettype wire
